// *** core/gpps_pkg.sv ***
// Purpose: Constants and types shared by the eight-pin port block.
// Assumes: One 100 MHz clock, asynchronous active-low reset.
// Notes: Offsets are byte offsets inside the main and the virtual map.
//
// Operation
// (R1) Input value bit n reads pin n.
// (R2) Disabled input buffer stops sampling the pin.
// (R3) Writing input value toggles output bits.
// (R4) Flag set when pin matches sense setting.
// (R5) Write one clears flag, zero keeps.
// (R6) Port control bit 0 limits slew.
// (R7) Config bit 7 inverts input and output.
// (R8) Config bit 3 enables the pull-up.
// (R9) Sense 0x0: no interrupt, buffer on.
// (R10) Sense 0x1 both, 0x2 rise, 0x3 fall.
// (R11) Sense 0x4: interrupt and buffer off.
// (R12) Sense 0x5 flags low level; 0x6-0x7 reserved.
// (R13) Virtual offsets 0x00-0x03 alias main registers.
// (R14) Virtual direction bit enables pin driver.
// (R15) Virtual output bit sets driven level.
// (R16) Virtual input write toggles output bits.
// (R17) Virtual flag needs match and enabled sense.
// (R18) Virtual flag write one clears flag.
// (R19) Interrupt request holds while enabled flags set.
// (R20) No new recognition three cycles after flag.
// (R21) Event output is pin value or zero.
// (R22) Direction enables driver; input stays active.
// (R23) Pins pass two synchroniser flops first.

package gpps_pkg;

    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned PIN_IDX_W = 3;

    // ****************************************************************
    // Main port map.
    // ****************************************************************
    localparam logic [4:0] OFF_DIR = 5'h00;
    localparam logic [4:0] OFF_OUT = 5'h04;
    localparam logic [4:0] OFF_IN = 5'h08;
    localparam logic [4:0] OFF_FLAGS = 5'h09;
    localparam logic [4:0] OFF_PORT_CTRL = 5'h0A;
    localparam logic [4:0] OFF_PIN_CFG = 5'h10;
    localparam logic [4:0] PIN_CFG_IDX_MASK = 5'h07;

    // ****************************************************************
    // Virtual port map.
    // ****************************************************************
    localparam logic [4:0] VOFF_DIR = 5'h00;
    localparam logic [4:0] VOFF_OUT = 5'h01;
    localparam logic [4:0] VOFF_IN = 5'h02;
    localparam logic [4:0] VOFF_FLAGS = 5'h03;

    // ****************************************************************
    // Field positions and reset values.
    // ****************************************************************
    localparam int unsigned SLEW_BIT = 0;
    localparam int unsigned CFG_INVERT_BIT = 7;
    localparam int unsigned CFG_PULLUP_BIT = 3;
    localparam int unsigned CFG_SENSE_LSB = 0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Cycles during which a pin ignores a new match after being flagged.
    localparam logic [1:0] DEAD_CYCLES = 2'h3;
    localparam logic [1:0] DEAD_NONE = 2'h0;
    localparam logic [1:0] DEAD_STEP = 2'h1;

    typedef enum logic [2:0] {
        GPPS_SENSE_OFF = 3'h0,
        GPPS_SENSE_ANY_EDGE = 3'h1,
        GPPS_SENSE_RISE = 3'h2,
        GPPS_SENSE_FALL = 3'h3,
        GPPS_SENSE_BUF_OFF = 3'h4,
        GPPS_SENSE_LOW = 3'h5,
        GPPS_SENSE_RSV6 = 3'h6,
        GPPS_SENSE_RSV7 = 3'h7
    } gpps_sense_t;

    typedef struct packed {
        logic invert_io_en;
        logic pullup_en_a;
        gpps_sense_t sense_select;
    } gpps_pin_cfg_t;

    localparam gpps_pin_cfg_t PIN_CFG_RESET = '{1'b0, 1'b0, GPPS_SENSE_OFF};

endpackage

// *** core/gpps_sync2.sv ***
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs arrive from outside the clock domain.
// Notes: Only the second stage leaves the module.

`timescale 1ns/1ps

module gpps_sync2 #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } gpps_sync_state_t;

    gpps_sync_state_t st_q;
    gpps_sync_state_t st_d;

    // ****************************************************************
    // Two stages.
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        // (R23) First stage capture.
        st_d.stage1 = async_i;
        st_d.stage2 = st_q.stage1;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sync_o = st_q.stage2;

endmodule

// *** core/gpps_pin_sense.sv ***
// Purpose: Edge and level sense with a sticky flag for one pin.
// Assumes: The level input is synchronised, inverted and gated already.
// Notes: A hardware set wins over a clear in the same cycle.

`timescale 1ns/1ps

module gpps_pin_sense (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic level_i,
    input wire gpps_pkg::gpps_sense_t sense_i,
    input wire logic clear_i,
    output logic flag_o
);

    typedef struct packed {
        logic prev;
        logic flag;
        logic [1:0] dead;
    } gpps_sense_state_t;

    gpps_sense_state_t st_q;
    gpps_sense_state_t st_d;
    logic rise;
    logic fall;
    logic match;

    // ****************************************************************
    // Match detection.
    // ****************************************************************
    assign rise = level_i & ~st_q.prev;
    assign fall = ~level_i & st_q.prev;

    always_comb
    begin
        match = 1'b0;
        case (sense_i)
            // (R10) Edge selection.
            gpps_pkg::GPPS_SENSE_ANY_EDGE: match = rise | fall;
            gpps_pkg::GPPS_SENSE_RISE: match = rise;
            gpps_pkg::GPPS_SENSE_FALL: match = fall;
            // (R12) Low level sense.
            gpps_pkg::GPPS_SENSE_LOW: match = ~level_i;
            // (R9) Disabled sense codes.
            default: match = 1'b0;
        endcase
    end

    // ****************************************************************
    // Flag and dead time.
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        st_d.prev = level_i;
        if (st_q.dead != gpps_pkg::DEAD_NONE)
        begin
            st_d.dead = st_q.dead - gpps_pkg::DEAD_STEP;
        end
        // (R5) Write one clears flag.
        if (clear_i)
        begin
            st_d.flag = 1'b0;
        end
        // (R20) Dead time gate.
        if (match && st_q.dead == gpps_pkg::DEAD_NONE)
        begin
            // (R4) Flag on match.
            st_d.flag = 1'b1;
            st_d.dead = gpps_pkg::DEAD_CYCLES;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;

endmodule

// *** core/gpps_port.sv ***
// Purpose: Eight-pin port with input sense flags and a virtual alias map.
// Assumes: Single-cycle register port, reads answered one cycle later.
// Notes: Pin inputs are synchronised before any use.

`timescale 1ns/1ps

module gpps_port (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_virt_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [7:0] pin_in_i,
    output logic [7:0] pin_out_o,
    output logic [7:0] pin_oe_n_o,
    output logic [7:0] pullup_en_a_o,
    output logic slew_limit_en_o,
    output logic [7:0] event_o,
    output logic irq_o
);

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] out;
        logic slew;
        gpps_pkg::gpps_pin_cfg_t [7:0] cfg;
        logic [7:0] rdata;
        logic [7:0] drive;
        logic [7:0] drive_oe_n;
        logic [7:0] events;
    } gpps_port_state_t;

    localparam gpps_port_state_t STATE_RESET = '{
        dir: gpps_pkg::BYTE_RESET,
        out: gpps_pkg::BYTE_RESET,
        slew: 1'b0,
        cfg: {gpps_pkg::PIN_COUNT{gpps_pkg::PIN_CFG_RESET}},
        rdata: gpps_pkg::BYTE_RESET,
        drive: gpps_pkg::BYTE_RESET,
        drive_oe_n: ~gpps_pkg::BYTE_RESET,
        events: gpps_pkg::BYTE_RESET
    };

    gpps_port_state_t st_q;
    gpps_port_state_t st_d;

    logic [7:0] pin_sync;
    logic [7:0] buf_en;
    logic [7:0] sense_en;
    logic [7:0] in_value;
    logic [7:0] flags;
    logic [7:0] flag_clr;
    logic [7:0] out_tgl;
    logic cfg_hit;
    logic [2:0] cfg_idx;

    // ****************************************************************
    // Pin synchroniser.
    // ****************************************************************
    // (R23) Two flops on every pin.
    gpps_sync2 #(
        .WIDTH(gpps_pkg::PIN_COUNT)
    ) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i(pin_in_i),
        .sync_o(pin_sync)
    );

    // ****************************************************************
    // Input path.
    // ****************************************************************
    always_comb
    begin
        for (int n = 0; n < gpps_pkg::PIN_COUNT; n++)
        begin
            // (R11) Buffer off code.
            buf_en[n] = st_q.cfg[n].sense_select != gpps_pkg::GPPS_SENSE_BUF_OFF;
            // (R17) Interrupt source codes.
            sense_en[n] = (st_q.cfg[n].sense_select == gpps_pkg::GPPS_SENSE_ANY_EDGE)
                || (st_q.cfg[n].sense_select == gpps_pkg::GPPS_SENSE_RISE)
                || (st_q.cfg[n].sense_select == gpps_pkg::GPPS_SENSE_FALL)
                || (st_q.cfg[n].sense_select == gpps_pkg::GPPS_SENSE_LOW);
            // (R1) Pin level with inversion; (R2) gated when buffer off.
            in_value[n] = buf_en[n] & (pin_sync[n] ^ st_q.cfg[n].invert_io_en);
        end
    end

    // ****************************************************************
    // Sense per pin.
    // ****************************************************************
    for (genvar g = 0; g < gpps_pkg::PIN_COUNT; g++)
    begin : g_sense
        gpps_pin_sense u_sense (
            .clk_i(clk_i),
            .reset_n_i(reset_n_i),
            .level_i(in_value[g]),
            .sense_i(st_q.cfg[g].sense_select),
            .clear_i(flag_clr[g]),
            .flag_o(flags[g])
        );
    end

    // ****************************************************************
    // Address decode.
    // ****************************************************************
    assign cfg_hit = !reg_virt_i
        && ((reg_addr_i & ~gpps_pkg::PIN_CFG_IDX_MASK) == gpps_pkg::OFF_PIN_CFG);
    assign cfg_idx = reg_addr_i[gpps_pkg::PIN_IDX_W-1:0];

    // ****************************************************************
    // Register writes.
    // ****************************************************************
    always_comb
    begin
        flag_clr = gpps_pkg::BYTE_ZERO;
        out_tgl = gpps_pkg::BYTE_ZERO;
        st_d = st_q;
        if (reg_wr_i)
        begin
            if (reg_virt_i)
            begin
                // (R13) Virtual alias writes.
                case (reg_addr_i)
                    // (R14) Virtual direction.
                    gpps_pkg::VOFF_DIR: st_d.dir = reg_wdata_i;
                    // (R15) Virtual output level.
                    gpps_pkg::VOFF_OUT: st_d.out = reg_wdata_i;
                    // (R16) Virtual input toggles.
                    gpps_pkg::VOFF_IN: out_tgl = reg_wdata_i;
                    // (R18) Virtual flag clear.
                    gpps_pkg::VOFF_FLAGS: flag_clr = reg_wdata_i;
                    default: out_tgl = gpps_pkg::BYTE_ZERO;
                endcase
            end
            else if (cfg_hit)
            begin
                // (R7) Inversion bit store.
                st_d.cfg[cfg_idx].invert_io_en = reg_wdata_i[gpps_pkg::CFG_INVERT_BIT];
                // (R8) Pull-up bit store.
                st_d.cfg[cfg_idx].pullup_en_a = reg_wdata_i[gpps_pkg::CFG_PULLUP_BIT];
                st_d.cfg[cfg_idx].sense_select = gpps_pkg::gpps_sense_t'(
                    reg_wdata_i[gpps_pkg::CFG_SENSE_LSB +: 3]);
            end
            else
            begin
                case (reg_addr_i)
                    gpps_pkg::OFF_DIR: st_d.dir = reg_wdata_i;
                    gpps_pkg::OFF_OUT: st_d.out = reg_wdata_i;
                    // (R3) Input write toggles output.
                    gpps_pkg::OFF_IN: out_tgl = reg_wdata_i;
                    // (R5) Flag clear by one.
                    gpps_pkg::OFF_FLAGS: flag_clr = reg_wdata_i;
                    // (R6) Slew limit bit.
                    gpps_pkg::OFF_PORT_CTRL: st_d.slew = reg_wdata_i[gpps_pkg::SLEW_BIT];
                    default: out_tgl = gpps_pkg::BYTE_ZERO;
                endcase
            end
        end
        st_d.out = st_d.out ^ out_tgl;

        // ************************************************************
        // Pin drive.
        // ************************************************************
        for (int n = 0; n < gpps_pkg::PIN_COUNT; n++)
        begin
            // (R7) Output inversion.
            st_d.drive[n] = st_d.out[n] ^ st_d.cfg[n].invert_io_en;
        end
        // (R22) Direction enables the driver only.
        st_d.drive_oe_n = ~st_d.dir;
        // (R21) Event follows gated input value.
        st_d.events = in_value;

        // ************************************************************
        // Register reads.
        // ************************************************************
        if (reg_rd_i)
        begin
            st_d.rdata = gpps_pkg::BYTE_ZERO;
            if (reg_virt_i)
            begin
                case (reg_addr_i)
                    gpps_pkg::VOFF_DIR: st_d.rdata = st_q.dir;
                    gpps_pkg::VOFF_OUT: st_d.rdata = st_q.out;
                    gpps_pkg::VOFF_IN: st_d.rdata = in_value;
                    gpps_pkg::VOFF_FLAGS: st_d.rdata = flags;
                    default: st_d.rdata = gpps_pkg::BYTE_ZERO;
                endcase
            end
            else if (cfg_hit)
            begin
                st_d.rdata[gpps_pkg::CFG_INVERT_BIT] = st_q.cfg[cfg_idx].invert_io_en;
                st_d.rdata[gpps_pkg::CFG_PULLUP_BIT] = st_q.cfg[cfg_idx].pullup_en_a;
                st_d.rdata[gpps_pkg::CFG_SENSE_LSB +: 3] = st_q.cfg[cfg_idx].sense_select;
            end
            else
            begin
                case (reg_addr_i)
                    gpps_pkg::OFF_DIR: st_d.rdata = st_q.dir;
                    gpps_pkg::OFF_OUT: st_d.rdata = st_q.out;
                    // (R1) Input value read.
                    gpps_pkg::OFF_IN: st_d.rdata = in_value;
                    gpps_pkg::OFF_FLAGS: st_d.rdata = flags;
                    gpps_pkg::OFF_PORT_CTRL: st_d.rdata[gpps_pkg::SLEW_BIT] = st_q.slew;
                    default: st_d.rdata = gpps_pkg::BYTE_ZERO;
                endcase
            end
        end
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_q <= STATE_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    always_comb
    begin
        for (int n = 0; n < gpps_pkg::PIN_COUNT; n++)
        begin
            // (R8) Pull-up enable per pin.
            pullup_en_a_o[n] = st_q.cfg[n].pullup_en_a;
        end
    end

    assign reg_rdata_o = st_q.rdata;
    assign pin_out_o = st_q.drive;
    assign pin_oe_n_o = st_q.drive_oe_n;
    // (R6) Slew limit for all pins.
    assign slew_limit_en_o = st_q.slew;
    assign event_o = st_q.events;
    // (R19) Request while enabled flags set.
    assign irq_o = |(flags & sense_en);

endmodule

// *** verification/gpps_pin_model.sv ***
// Purpose: Pin-side circuitry for the eight-pin port block.
// Assumes: The bench selects which pins it drives and to what level.
// Notes: A pin that no party drives and that has no pull-up floats.

`timescale 1ns/1ps

module gpps_pin_model (
    input wire logic clk_i,
    input wire logic [7:0] pin_out_i,
    input wire logic [7:0] pin_oe_n_i,
    input wire logic [7:0] pullup_en_i,
    input wire logic [7:0] drive_en_i,
    input wire logic [7:0] drive_level_i,
    output logic [7:0] pin_o
);
    // A floating pin changes every cycle so it never reads as a steady level.
    logic [7:0] float_q = 8'h55;

    always @(posedge clk_i)
    begin
        float_q <= ~float_q;
    end

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!pin_oe_n_i[i])
                pin_o[i] = pin_out_i[i];
            else if (drive_en_i[i])
                pin_o[i] = drive_level_i[i];
            else if (pullup_en_i[i])
                pin_o[i] = 1'b1;
            else
                pin_o[i] = float_q[i];
        end
    end
endmodule

// *** verification/gpps_port_assertions.sv ***
// Purpose: Port-level checks for the eight-pin port block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to every instance of the port block.

`timescale 1ns/1ps

module gpps_port_assertions (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_virt_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [7:0] pin_in_i,
    input wire logic [7:0] pin_out_o,
    input wire logic [7:0] pin_oe_n_o,
    input wire logic [7:0] pullup_en_a_o,
    input wire logic slew_limit_en_o,
    input wire logic [7:0] event_o,
    input wire logic irq_o
);
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    slew_write_a:
    assert property (reg_wr_i && !reg_virt_i && reg_addr_i == 5'h0A
        |=> slew_limit_en_o == $past(reg_wdata_i[0]))
    else $error("slew limit does not follow port control write");
    dir_write_a:
    assert property (reg_wr_i && reg_addr_i == 5'h00 |=> pin_oe_n_o == ~$past(reg_wdata_i))
    else $error("driver enable does not follow direction write");
    in_toggle_a:
    assert property (reg_wr_i && reg_addr_i == (reg_virt_i ? 5'h02 : 5'h08)
        |=> pin_out_o == ($past(pin_out_o) ^ $past(reg_wdata_i)))
    else $error("input value write did not toggle output");
    pullup_write_a:
    assert property (reg_wr_i && !reg_virt_i && reg_addr_i[4:3] == 2'h2
        |=> pullup_en_a_o[$past(reg_addr_i[2:0])] == $past(reg_wdata_i[3]))
    else $error("pull-up does not follow config write");
    out_hold_a:
    assert property (!$stable(pin_out_o) || !$stable(pin_oe_n_o) |-> $past(reg_wr_i))
    else $error("pin drive changed without a write");
    irq_hold_a:
    assert property ($fell(irq_o) |-> $past(reg_wr_i))
    else $error("interrupt request dropped without a write");
    dir_read_a:
    assert property (reg_rd_i && reg_addr_i == 5'h00 |=> reg_rdata_o == ~$past(pin_oe_n_o))
    else $error("direction read does not match driver enable");
    unmapped_read_a:
    assert property (reg_rd_i && (reg_virt_i ? reg_addr_i > 5'h03
        : reg_addr_i inside {[5'h0B:5'h0F]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
    rdata_hold_a:
    assert property (!$stable(reg_rdata_o) |-> $past(reg_rd_i))
    else $error("read data changed without a read");
endmodule

bind gpps_port gpps_port_assertions u_chk (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_virt_i(reg_virt_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .pin_in_i(pin_in_i),
    .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o),
    .pullup_en_a_o(pullup_en_a_o),
    .slew_limit_en_o(slew_limit_en_o),
    .event_o(event_o),
    .irq_o(irq_o)
);

// *** verification/gpps_port_test.sv ***
// Purpose: Self-checking bench for the eight-pin port block.
// Assumes: Inputs change on the falling clock edge.
// Notes: Pins are driven through the pin model.

`timescale 1ns/1ps

module gpps_port_test;
    typedef struct packed {
        logic wv;
        logic [4:0] wa;
        logic [7:0] wd;
        logic rv;
        logic [4:0] ra;
        logic [7:0] ex;
    } gpps_row_t;

    logic clk, reset_n, reg_wr, reg_rd, reg_virt, slew, irq;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, oe_n, pu, evt, ext_en, ext_lvl;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    gpps_row_t rows [6] = '{
        '{1'b0, 5'h00, 8'hA5, 1'b1, 5'h00, 8'hA5},
        '{1'b1, 5'h01, 8'h5A, 1'b0, 5'h04, 8'h5A},
        '{1'b0, 5'h0A, 8'h01, 1'b0, 5'h0A, 8'h01},
        '{1'b0, 5'h10, 8'hFF, 1'b0, 5'h10, 8'h8F},
        '{1'b0, 5'h0B, 8'hFF, 1'b0, 5'h0B, 8'h00},
        '{1'b1, 5'h05, 8'hFF, 1'b1, 5'h05, 8'h00}};
    logic [4:0] rst_addrs [6] = '{5'h00, 5'h04, 5'h08, 5'h09, 5'h0A, 5'h10};
    logic [2:0] senses [6] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h5, 3'h6};

    gpps_port DUT (.clk_i(clk), .reset_n_i(reset_n), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_virt_i(reg_virt), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(oe_n),
        .pullup_en_a_o(pu), .slew_limit_en_o(slew), .event_o(evt), .irq_o(irq));
    gpps_pin_model u_pins (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_n_i(oe_n),
        .pullup_en_i(pu), .drive_en_i(ext_en), .drive_level_i(ext_lvl), .pin_o(pin_in));

    // ********************************************************
    // Tasks.
    // ********************************************************
    task automatic results;
    begin
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
    begin
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task automatic write_reg(input logic v, input logic [4:0] a, input logic [7:0] d);
    begin
        @(negedge clk);
        reg_wr = 1'b1;
        reg_virt = v;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    end
    endtask

    task automatic expect_reg(input logic v, input logic [4:0] a, input logic [7:0] exp);
    begin
        @(negedge clk);
        reg_rd = 1'b1;
        reg_virt = v;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        check(reg_rdata, exp);
    end
    endtask

    task automatic do_reset;
    begin
        reset_n = 1'b0;
        repeat (8) @(negedge clk);
        check(oe_n, 8'hFF);
        check(pin_out | pu, 8'h00);
        check({6'h00, slew, irq}, 8'h00);
        reset_n = 1'b1;
    end
    endtask

    // ********************************************************
    // Clock, timeout and main sequence.
    // ********************************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            results();
        end
    end

    initial
    begin
        {reg_wr, reg_rd, reg_virt, reg_addr, reg_wdata, ext_lvl} = '0;
        ext_en = 8'hFF;
        do_reset();
        foreach (rst_addrs[i]) expect_reg(1'b0, rst_addrs[i], 8'h00);
        foreach (rows[i])
        begin
            write_reg(rows[i].wv, rows[i].wa, rows[i].wd);
            expect_reg(rows[i].rv, rows[i].ra, rows[i].ex);
        end
        check(pin_out, 8'h5B);
        check({pu[6:0], slew}, 8'h03);
        check(oe_n, 8'h5A);
        write_reg(1'b0, 5'h08, 8'h0F);
        expect_reg(1'b0, 5'h04, 8'h55);
        write_reg(1'b1, 5'h02, 8'hF0);
        expect_reg(1'b1, 5'h01, 8'hA5);
        expect_reg(1'b0, 5'h08, 8'hA5);
        do_reset();
        ext_lvl = 8'hC3;
        repeat (4) @(negedge clk);
        expect_reg(1'b0, 5'h08, 8'hC3);
        expect_reg(1'b1, 5'h02, 8'hC3);
        write_reg(1'b0, 5'h11, 8'h80);
        expect_reg(1'b0, 5'h08, 8'hC1);
        write_reg(1'b0, 5'h10, 8'h04);
        expect_reg(1'b0, 5'h08, 8'hC0);
        check(evt, 8'hC0);
        foreach (senses[i]) write_reg(1'b0, 5'h12 + 5'(i), {5'h00, senses[i]});
        repeat (4) @(negedge clk);
        write_reg(1'b0, 5'h09, 8'hFF);
        expect_reg(1'b0, 5'h09, 8'h00);
        ext_lvl = 8'h3F;
        repeat (6) @(negedge clk);
        expect_reg(1'b0, 5'h09, 8'h4C);
        check({7'h00, irq}, 8'h01);
        write_reg(1'b0, 5'h09, 8'h04);
        expect_reg(1'b0, 5'h09, 8'h48);
        ext_lvl = 8'hC3;
        repeat (6) @(negedge clk);
        expect_reg(1'b1, 5'h03, 8'h5C);
        write_reg(1'b1, 5'h03, 8'hFF);
        expect_reg(1'b0, 5'h09, 8'h00);
        check({7'h00, irq}, 8'h00);
        ext_lvl[3] = 1'b1;
        @(negedge clk);
        ext_lvl[3] = 1'b0;
        @(negedge clk);
        ext_lvl[3] = 1'b1;
        write_reg(1'b0, 5'h09, 8'h08);
        expect_reg(1'b0, 5'h09, 8'h00);
        ext_lvl[3] = 1'b0;
        ext_en = 8'hDF;
        write_reg(1'b0, 5'h00, 8'h20);
        write_reg(1'b0, 5'h04, 8'h20);
        repeat (2) @(negedge clk);
        expect_reg(1'b0, 5'h08, 8'hE0);
        check(oe_n, 8'hDF);
        write_reg(1'b0, 5'h15, 8'h08);
        write_reg(1'b0, 5'h00, 8'h00);
        repeat (4) @(negedge clk);
        expect_reg(1'b0, 5'h08, 8'hE0);
        results();
    end
endmodule
